// file: hdl/pio_read_packer.sv
// packs pio read dwords into qwords, trimming the tail to the byte count
`include "sata_err_regs.svh"

module pio_read_packer #(
	parameter int CNT_W = `CNT_W
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic [CNT_W-1:0] count_i,
	output logic [CNT_W-1:0] left_o,
	input wire logic [31:0] rx_data_i,
	input wire logic rx_valid_i,
	output logic rx_ready_o,
	output logic [63:0] out_data_o,
	output logic [7:0] out_strb_o,
	output logic out_last_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	logic active_ff;
	logic half_ff;
	logic [CNT_W-1:0] left_ff;
	logic [31:0] lo_ff;
	logic [2:0] take;
	logic [CNT_W-1:0] rem;
	logic accept;
	logic [CNT_W-1:0] sum_ff;
	logic [CNT_W-1:0] total_ff;

	function automatic logic [3:0] lane_mask(input logic [2:0] n);
		unique case (n)
			3'h1: lane_mask = 4'h1;
			3'h2: lane_mask = 4'h3;
			3'h3: lane_mask = 4'h7;
			default: lane_mask = 4'hf;
		endcase
	endfunction

	// the tail dword may carry fewer valid bytes than four
	assign take = (left_ff >= CNT_W'(`LANE_BYTES)) ? 3'h4 : left_ff[2:0];
	assign rem = left_ff - CNT_W'(take);
	// stall the link while a packed qword waits for the reader
	assign rx_ready_o = active_ff & ~out_valid_o;
	assign accept = rx_valid_i & rx_ready_o;
	assign left_o = left_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			active_ff <= 1'b0;
			left_ff <= '0;
			half_ff <= 1'b0;
		end else if (start_i) begin
			active_ff <= (count_i != '0);
			left_ff <= count_i;
			half_ff <= 1'b0;
		end else if (accept) begin
			left_ff <= rem;
			half_ff <= ~half_ff & (rem != '0);
			if (rem == '0) begin
				active_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lo_ff <= 32'h0;
			out_valid_o <= 1'b0;
			out_data_o <= 64'h0;
			out_strb_o <= 8'h0;
			out_last_o <= 1'b0;
		end else if (accept && (half_ff || rem == '0)) begin
			out_valid_o <= 1'b1;
			out_last_o <= (rem == '0);
			if (half_ff) begin
				out_data_o <= {rx_data_i, lo_ff};
				out_strb_o <= {lane_mask(take), 4'hf};
			end else begin
				out_data_o <= {32'h0, rx_data_i};
				out_strb_o <= {4'h0, lane_mask(take)};
			end
		end else begin
			if (accept) begin
				lo_ff <= rx_data_i;
			end
			if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || start_i) begin
			sum_ff <= '0;
			total_ff <= count_i;
		end else if (out_valid_o && out_ready_i) begin
			sum_ff <= sum_ff + CNT_W'($countones(out_strb_o));
		end
	end

	chk_pio_last_word: assert property (@(posedge clk_i) disable iff (srst_i)
		accept && !start_i && rem == '0 |=> out_valid_o && out_last_o)
		else $error("final pio dword did not produce a last qword");

	chk_pio_byte_total: assert property (@(posedge clk_i) disable iff (srst_i)
		out_valid_o && out_ready_i && out_last_o && !start_i
		|-> sum_ff + CNT_W'($countones(out_strb_o)) == total_ff)
		else $error("pio bytes delivered differ from the transfer count");
endmodule

// file: hdl/sata_err_pkg.sv
// types shared by the port error block
package sata_err_pkg;
	typedef enum {
		SEL_ISTAT,
		SEL_IMASK,
		SEL_CTRL,
		SEL_FBS,
		SEL_CI,
		SEL_PIO,
		SEL_NONE
	} reg_sel_t;
	typedef logic [3:0] pmp_t;
endpackage

// file: hdl/sata_err_regs.svh
// register offsets, field positions and reset values of the port error block
`ifndef SATA_ERR_REGS_SVH
`define SATA_ERR_REGS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ISTAT_OFS 8'h00
`define IMASK_OFS 8'h04
`define CTRL_OFS 8'h08
`define FBS_OFS 8'h0c
`define CI_OFS 8'h10
`define PIO_OFS 8'h14

// ------------------------------------------------------------
// status and mask bit positions
// ------------------------------------------------------------
`define ST_IFS 0
`define ST_INFS 1
`define ST_PCS 2
`define ST_W 3
`define IMASK_RST 3'h0

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_START 0
`define CTRL_FBS 1
`define CTRL_IDE 2
`define CTRL_PMP_LO 8
`define CTRL_PMP_HI 11
`define CTRL_W 12
`define CTRL_RST 12'h000

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define PMP_W 4
`define CNT_W 16
`define LANE_BYTES 4

`endif

// file: hdl/sata_port_error_handling.sv
// port error, halt and command issue handling with an avalon register slave
// What this block does
// - host non-data escape sets fatal flag
// - r_err on host non-data sets nonfatal flag
// - device non-data escape sets fatal flag
// - switching on: host escape records erring port
// - switching on: completions clear only owner slots
// - connect change flag halts command execution
// - ide pio read handles unaligned counts
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`include "sata_err_regs.svh"

module sata_port_error_handling #(
	parameter int SLOTS = 8,
	parameter int SLOT_W = 3
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic h2d_sync_escape_i,
	input wire logic h2d_rerr_i,
	input wire logic d2h_sync_escape_i,
	input wire logic [`PMP_W-1:0] fis_pmp_i,
	input wire logic cominit_i,
	input wire logic power_saving_i,
	input wire logic d2h_done_i,
	input wire logic [SLOT_W-1:0] d2h_slot_i,
	input wire logic [`PMP_W-1:0] d2h_pmp_i,
	output logic cmd_valid_o,
	input wire logic cmd_ready_i,
	output logic [SLOT_W-1:0] cmd_slot_o,
	output logic [`PMP_W-1:0] cmd_pmp_o,
	input wire logic [31:0] pio_rx_data_i,
	input wire logic pio_rx_valid_i,
	output logic pio_rx_ready_o,
	output logic [63:0] pio_data_o,
	output logic [7:0] pio_strb_o,
	output logic pio_last_o,
	output logic pio_valid_o,
	input wire logic pio_ready_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic ack_ff;
	logic wr_ack;
	logic rd_ack;
	sata_err_pkg::reg_sel_t sel;

	function automatic sata_err_pkg::reg_sel_t decode(input logic [7:0] addr);
		unique case (addr)
			`ISTAT_OFS: decode = sata_err_pkg::SEL_ISTAT;
			`IMASK_OFS: decode = sata_err_pkg::SEL_IMASK;
			`CTRL_OFS: decode = sata_err_pkg::SEL_CTRL;
			`FBS_OFS: decode = sata_err_pkg::SEL_FBS;
			`CI_OFS: decode = sata_err_pkg::SEL_CI;
			`PIO_OFS: decode = sata_err_pkg::SEL_PIO;
			default: decode = sata_err_pkg::SEL_NONE;
		endcase
	endfunction

	assign sel = decode(avs_address_i);
	// every access takes exactly one wait cycle, so read data can come from a flop
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
	assign wr_ack = avs_write_i & ack_ff;
	assign rd_ack = avs_read_i & ack_ff;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
		end
	end

	// ------------------------------------------------------------
	// control, mask and switching fields
	// ------------------------------------------------------------
	logic [`CTRL_W-1:0] ctrl_ff;
	logic [`ST_W-1:0] imask_ff;
	logic [`PMP_W-1:0] dwe_ff;
	logic started;
	logic fbs_on;
	logic [`PMP_W-1:0] issue_pmp;

	assign started = ctrl_ff[`CTRL_START];
	assign fbs_on = ctrl_ff[`CTRL_FBS];
	assign issue_pmp = ctrl_ff[`CTRL_PMP_HI:`CTRL_PMP_LO];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_ff <= `CTRL_RST;
		end else if (wr_ack && sel == sata_err_pkg::SEL_CTRL) begin
			ctrl_ff <= avs_writedata_i[`CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			imask_ff <= `IMASK_RST;
		end else if (wr_ack && sel == sata_err_pkg::SEL_IMASK) begin
			imask_ff <= avs_writedata_i[`ST_W-1:0];
		end
	end

	// the port multiplier port of the failing fis is kept for error recovery
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dwe_ff <= '0;
		end else if (h2d_sync_escape_i && fbs_on) begin
			dwe_ff <= fis_pmp_i;
		end
	end

	// ------------------------------------------------------------
	// error status and interrupt
	// ------------------------------------------------------------
	logic [`ST_W-1:0] stat_ff;
	logic [`ST_W-1:0] set_vec;
	logic [`ST_W-1:0] rd_clr;
	logic halt;

	always_comb begin
		set_vec = '0;
		set_vec[`ST_IFS] = h2d_sync_escape_i
			| d2h_sync_escape_i
			| (cominit_i & power_saving_i);
		set_vec[`ST_INFS] = h2d_rerr_i;
		set_vec[`ST_PCS] = cominit_i;
	end

	// only the bits actually returned are cleared, so a late event survives
	assign rd_clr = (rd_ack && sel == sata_err_pkg::SEL_ISTAT) ?
		avs_readdata_o[`ST_W-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~rd_clr) | set_vec;
		end
	end

	// a pending connect change freezes dispatch until software reads it away
	assign halt = stat_ff[`ST_PCS];
	assign irq_o = |(stat_ff & imask_ff);

	// ------------------------------------------------------------
	// command issue bookkeeping
	// ------------------------------------------------------------
	logic [SLOTS-1:0] ci_ff;
	logic [SLOTS-1:0] disp_ff;
	logic [`PMP_W-1:0] own_ff [SLOTS];
	logic [SLOTS-1:0] issue_bits;
	logic [SLOTS-1:0] done_bits;
	logic [SLOTS-1:0] take_bits;
	logic [SLOTS-1:0] waiting;
	logic [SLOT_W-1:0] pick;
	logic cmd_valid_ff;

	// a slot already in use cannot be issued again
	assign issue_bits = (wr_ack && sel == sata_err_pkg::SEL_CI) ?
		avs_writedata_i[SLOTS-1:0] & ~ci_ff : '0;
	assign waiting = ci_ff & ~disp_ff;

	always_comb begin
		done_bits = '0;
		// with switching on, a reply from one port never retires another port's slot
		if (d2h_done_i && ci_ff[d2h_slot_i] &&
			(!fbs_on || own_ff[d2h_slot_i] == d2h_pmp_i)) begin
			done_bits[d2h_slot_i] = 1'b1;
		end
	end

	always_comb begin
		pick = '0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (waiting[i]) begin
				pick = SLOT_W'(i);
			end
		end
	end

	always_comb begin
		take_bits = '0;
		if (cmd_valid_o && cmd_ready_i) begin
			take_bits[cmd_slot_o] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || !started) begin
			ci_ff <= '0;
			disp_ff <= '0;
		end else begin
			ci_ff <= (ci_ff & ~done_bits) | issue_bits;
			disp_ff <= (disp_ff & ~done_bits) | take_bits;
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < SLOTS; i++) begin
			if (srst_i) begin
				own_ff[i] <= '0;
			end else if (issue_bits[i]) begin
				own_ff[i] <= issue_pmp;
			end
		end
	end

	// ------------------------------------------------------------
	// command dispatch
	// ------------------------------------------------------------
	assign cmd_valid_o = cmd_valid_ff & ~halt;

	always_ff @(posedge clk_i) begin
		if (srst_i || !started) begin
			cmd_valid_ff <= 1'b0;
			cmd_slot_o <= '0;
			cmd_pmp_o <= '0;
		end else if (cmd_valid_o && cmd_ready_i) begin
			cmd_valid_ff <= 1'b0;
		end else if (!cmd_valid_ff && !halt && |waiting) begin
			cmd_valid_ff <= 1'b1;
			cmd_slot_o <= pick;
			cmd_pmp_o <= own_ff[pick];
		end
	end

	// ------------------------------------------------------------
	// pio read path
	// ------------------------------------------------------------
	logic pio_start;
	logic [`CNT_W-1:0] pio_left;

	// pio reads exist only in ide compatibility mode
	assign pio_start = wr_ack && sel == sata_err_pkg::SEL_PIO &&
		ctrl_ff[`CTRL_IDE];

	pio_read_packer #(
		.CNT_W(`CNT_W)
	) u_packer (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.start_i(pio_start),
		.count_i(avs_writedata_i[`CNT_W-1:0]),
		.left_o(pio_left),
		.rx_data_i(pio_rx_data_i),
		.rx_valid_i(pio_rx_valid_i),
		.rx_ready_o(pio_rx_ready_o),
		.out_data_o(pio_data_o),
		.out_strb_o(pio_strb_o),
		.out_last_o(pio_last_o),
		.out_valid_o(pio_valid_o),
		.out_ready_i(pio_ready_i)
	);

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i && !ack_ff) begin
			avs_readdata_o <= 32'h0;
			unique case (sel)
				sata_err_pkg::SEL_ISTAT: avs_readdata_o[`ST_W-1:0] <= stat_ff;
				sata_err_pkg::SEL_IMASK: avs_readdata_o[`ST_W-1:0] <= imask_ff;
				sata_err_pkg::SEL_CTRL: avs_readdata_o[`CTRL_W-1:0] <= ctrl_ff;
				sata_err_pkg::SEL_FBS: avs_readdata_o[`PMP_W-1:0] <= dwe_ff;
				sata_err_pkg::SEL_CI: avs_readdata_o[SLOTS-1:0] <= ci_ff;
				sata_err_pkg::SEL_PIO: avs_readdata_o[`CNT_W-1:0] <= pio_left;
				sata_err_pkg::SEL_NONE: avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_ifs_host_escape: assert property (
		h2d_sync_escape_i |=> stat_ff[`ST_IFS])
		else $error("host fis escape did not set the fatal flag");

	chk_infs_rerr_set: assert property (
		h2d_rerr_i && !stat_ff[`ST_INFS]
		|=> stat_ff[`ST_INFS] && (irq_o || !imask_ff[`ST_INFS]))
		else $error("r_err did not set the nonfatal flag");

	chk_ifs_dev_escape: assert property (
		d2h_sync_escape_i |=> stat_ff[`ST_IFS])
		else $error("device fis escape did not set the fatal flag");

	chk_dwe_records_port: assert property (
		h2d_sync_escape_i && fbs_on |=> dwe_ff == $past(fis_pmp_i))
		else $error("erring port not recorded");

	chk_ci_foreign_keep: assert property (
		d2h_done_i && fbs_on && started && ci_ff[d2h_slot_i] &&
		own_ff[d2h_slot_i] != d2h_pmp_i &&
		!(wr_ack && sel == sata_err_pkg::SEL_CTRL)
		|=> ci_ff[$past(d2h_slot_i)])
		else $error("reply from another port retired a slot");

	chk_cominit_fatal: assert property (
		cominit_i && power_saving_i |=> stat_ff[`ST_IFS] && stat_ff[`ST_PCS])
		else $error("cominit in power saving not fatal");

	chk_halt_on_pcs: assert property (
		$rose(stat_ff[`ST_PCS]) |-> !cmd_valid_o [*2])
		else $error("commands dispatched while connect change pending");

	chk_no_issue_halted: assert property (
		stat_ff[`ST_PCS] |=> (disp_ff & ~$past(disp_ff)) == '0)
		else $error("command taken while connect change pending");

	chk_sticky_flags: assert property (
		!(rd_ack && sel == sata_err_pkg::SEL_ISTAT)
		|=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
		else $error("status flag dropped without a read");

	chk_irq_on_event: assert property (
		(set_vec & imask_ff) != '0 && !(wr_ack && sel == sata_err_pkg::SEL_IMASK) |=> irq_o)
		else $error("unmasked event did not raise the interrupt");
endmodule

// file: testbench/sata_far_end_model.sv
// far-end link model: device events, command taker and pio dword source
module sata_far_end_model (
	input wire logic clk_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	output logic [4:0] ev_o,
	output logic [3:0] pmp_o,
	output logic [2:0] slot_o,
	output logic [31:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 28898;
	initial begin
		cmd_ready_o = 1'b0;
		ev_o = 5'h00;
		pmp_o = 4'h0;
		slot_o = 3'h0;
		rx_data_o = 32'h0;
		rx_valid_o = 1'b0;
	end
	// takes offered commands promptly or after random stalls
	always @(posedge clk_i) begin
		cmd_ready_o <= cmd_valid_i & 1'($random(seed));
	end
	// ev bits: 0 host escape, 1 r_err, 2 device escape, 3 cominit, 4 completion
	task pulse(input int k, input logic [3:0] p, input logic [2:0] s);
		@(posedge clk_i);
		ev_o <= 5'h01 << k;
		pmp_o <= p;
		slot_o <= s;
		@(posedge clk_i);
		ev_o <= 5'h00;
		pmp_o <= ~p;
		slot_o <= ~s;
	endtask
	// released data shows the inverse so a stale value can never pass
	task send(input logic [31:0] d);
		@(posedge clk_i);
		rx_data_o <= d;
		rx_valid_o <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (rx_ready_i === 1'b1) break;
		end
		rx_valid_o <= 1'b0;
		rx_data_o <= ~d;
	endtask
endmodule

// file: testbench/sata_port_error_handling_tb_top.sv
// self-checking bench of the port error block
`include "sata_err_regs.svh"

module sata_port_error_handling_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_wdata = 32'h0;
	logic [31:0] avs_rdata;
	logic avs_wait, irq, cmd_valid, cmd_ready, rx_valid, rx_ready, pio_last, pio_valid;
	logic ps = 1'b0;
	logic pio_ready = 1'b0;
	logic [2:0] cmd_slot, ev_slot;
	logic [3:0] cmd_pmp, ev_pmp, rp;
	logic [4:0] ev;
	logic [31:0] rx_data;
	logic [63:0] pio_data;
	logic [7:0] pio_strb;
	logic [31:0] rq[$];
	logic [72:0] pq[$];
	logic [72:0] pe, sd;
	logic [31:0] exp_st [5] = '{32'h1, 32'h2, 32'h1, 32'h4, 32'h5};
	int seed = 28898;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;

	sata_port_error_handling #(.SLOTS(8), .SLOT_W(3)) dut (
		.clk_i(clk), .srst_i(srst), .avs_address_i(avs_address), .avs_read_i(avs_read),
		.avs_write_i(avs_write), .avs_writedata_i(avs_wdata), .avs_readdata_o(avs_rdata),
		.avs_waitrequest_o(avs_wait), .irq_o(irq), .h2d_sync_escape_i(ev[0]),
		.h2d_rerr_i(ev[1]), .d2h_sync_escape_i(ev[2]), .fis_pmp_i(ev_pmp), .cominit_i(ev[3]),
		.power_saving_i(ps), .d2h_done_i(ev[4]), .d2h_slot_i(ev_slot), .d2h_pmp_i(ev_pmp),
		.cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready), .cmd_slot_o(cmd_slot),
		.cmd_pmp_o(cmd_pmp), .pio_rx_data_i(rx_data), .pio_rx_valid_i(rx_valid),
		.pio_rx_ready_o(rx_ready), .pio_data_o(pio_data), .pio_strb_o(pio_strb),
		.pio_last_o(pio_last), .pio_valid_o(pio_valid), .pio_ready_i(pio_ready)
	);
	sata_far_end_model m (
		.clk_i(clk), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .ev_o(ev),
		.pmp_o(ev_pmp), .slot_o(ev_slot), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
		.rx_ready_i(rx_ready)
	);

	initial begin
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task chk(input logic [72:0] seen, input logic [72:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		chk(73'(rq.size() + pq.size()), 73'h0);
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pio_ready <= 1'($random(seed));
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	// read data is taken at the edge where waitrequest is sampled low
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_wait === 1'b0) begin
			chk(73'(avs_rdata), 73'(rq.pop_front()));
		end
	end
	// bytes outside the strobes carry no meaning, so both sides are blanked there
	always @(negedge clk) begin
		if (pio_valid === 1'b1 && pio_ready === 1'b1) begin
			pe = pq.pop_front();
			sd = {pio_data, pio_strb, pio_last};
			for (int i = 0; i < 8; i++) begin
				if (pe[i + 1] === 1'b0) begin
					pe[9 + 8 * i +: 8] = 8'h00;
					sd[9 + 8 * i +: 8] = 8'h00;
				end
			end
			chk(sd, pe);
		end
	end

	// ------------------------------------------------------------
	// bus master and sequences
	// ------------------------------------------------------------
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_wdata <= d;
		forever begin
			@(posedge clk);
			if (avs_wait === 1'b0) break;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic pio(input int n);
		logic [31:0] d[8];
		int b;
		for (int i = 0; i < 8; i++) d[i] = $random(seed);
		for (int q = 0; q * 8 < n; q++) begin
			b = (n - 8 * q > 8) ? 8 : n - 8 * q;
			pq.push_back({d[2 * q + 1], d[2 * q], 8'hff >> (8 - b), ((q + 1) * 8 >= n)});
		end
		bus(1'b1, `PIO_OFS, 32'(n));
		for (int i = 0; i * 4 < n; i++) m.send(d[i]);
		for (int i = 0; i < 50 && pq.size() > 0; i++) @(negedge clk);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(`IMASK_OFS, 32'h0);
		rd(`CTRL_OFS, 32'h0);
		rd(`FBS_OFS, 32'h0);
		rd(`CI_OFS, 32'h0);
		bus(1'b1, 8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0);
		for (int k = 0; k < 5; k++) begin
			ps <= (k == 4);
			m.pulse((k == 4) ? 3 : k, 4'h0, 3'h0);
			@(negedge clk);
			chk(73'(irq), 73'(k != 0));
			if (k == 0) begin
				bus(1'b1, `IMASK_OFS, 32'h7);
				@(negedge clk);
				chk(73'(irq), 73'h1);
			end
			rd(`ISTAT_OFS, exp_st[k]);
			rd(`ISTAT_OFS, 32'h0);
		end
		ps <= 1'b0;
		// start, switching on, issuing port 3
		bus(1'b1, `CTRL_OFS, 32'h303);
		rp = 4'($random(seed));
		m.pulse(0, rp, 3'h0);
		rd(`FBS_OFS, {28'h0, rp});
		rd(`ISTAT_OFS, 32'h1);
		m.pulse(3, 4'h0, 3'h0);
		bus(1'b1, `CI_OFS, 32'h1);
		repeat (6) begin
			@(negedge clk);
			chk(73'(cmd_valid), 73'h0);
		end
		rd(`ISTAT_OFS, 32'h4);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (cmd_valid === 1'b1) break;
		end
		chk(73'({cmd_valid, cmd_slot, cmd_pmp}), 73'({1'b1, 3'h0, 4'h3}));
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			if (cmd_valid === 1'b0) break;
		end
		m.pulse(4, 4'h5, 3'h0);
		rd(`CI_OFS, 32'h1);
		m.pulse(4, 4'h3, 3'h0);
		rd(`CI_OFS, 32'h0);
		bus(1'b1, `CTRL_OFS, 32'h4);
		pio(5);
		pio(12);
		rd(`PIO_OFS, 32'h0);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
